// ==== rtl/shs_pkg.sv ====
// Constants, types and helpers shared by the sensor two-wire port and sequencer.
package shs_pkg;
    localparam logic [6:0] SHS_DEV_ADDR = 7'h43;
    localparam logic [7:0] SHS_OFS_SYSCTL = 8'h10;
    localparam logic [7:0] SHS_OFS_SYSSTA = 8'h11;
    localparam logic [7:0] SHS_OFS_RUN = 8'h21;
    localparam logic [7:0] SHS_OFS_START = 8'h22;
    localparam logic [7:0] SHS_OFS_STOP = 8'h23;
    localparam logic [7:0] SHS_OFS_STAT = 8'h24;
    localparam logic [7:0] SHS_OFS_TVAL = 8'h30;
    localparam logic [7:0] SHS_OFS_HVAL = 8'h33;
    localparam logic SHS_LP_RST = 1'b1;
    localparam logic [3:0] SHS_BITS = 4'h8;
    localparam int SHS_STD_KBPS = 100;
    localparam int SHS_FAST_KBPS = 400;
    localparam int SHS_CLK_MHZ = 250;
    localparam int SHS_BOOT_US = 1000;
    localparam int SHS_TCONV_US = 104000;
    localparam int SHS_HCONV_US = 121000;
    localparam int SHS_BOOT_CYC = SHS_BOOT_US * SHS_CLK_MHZ;
    localparam int SHS_TCONV_CYC = SHS_TCONV_US * SHS_CLK_MHZ;
    localparam int SHS_HCONV_CYC = SHS_HCONV_US * SHS_CLK_MHZ;
    localparam int SHS_CNT_W = 27;
    localparam logic [7:0] SHS_CRC_POLY = 8'h89;
    localparam logic [6:0] SHS_CRC_IVEC = 7'h7f;

    typedef enum logic [1:0] {SQ_STANDBY, SQ_BOOT, SQ_IDLE, SQ_MEAS} shs_seq_e;
    typedef enum logic [2:0] {
        LK_IDLE, LK_ADDR, LK_PTR, LK_WDATA, LK_ACK, LK_RWAIT, LK_RDATA, LK_RACK
    } shs_link_e;

    // Register request carried from the link domain to the core domain.
    typedef struct packed {
        logic tgl;
        logic we;
        logic [7:0] addr;
        logic [7:0] wd;
    } shs_req_s;

    // Core state: control registers, sequencer and readout buffers.
    typedef struct packed {
        logic lp;
        logic [1:0] run;
        logic [1:0] start;
        logic [1:0] stop;
        logic [1:0] step;
        logic [1:0] stat;
        shs_seq_e seq;
        logic [SHS_CNT_W-1:0] cnt;
        logic active;
        logic [1:0][16:0] meas;
        logic [1:0][23:0] snap;
        logic [7:0] rdata;
        logic rq_s1;
        logic rq_s2;
        logic rq_s3;
        logic ack_tgl;
    } shs_core_s;

    // Link state: pin synchronisers and the two-wire slave.
    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_s3;
        logic sda_s1;
        logic sda_s2;
        logic sda_s3;
        logic ack_s1;
        logic ack_s2;
        shs_link_e st;
        shs_link_e ret;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] ptr;
        logic ackb;
        logic drv;
        shs_req_s req;
    } shs_link_s;

    // CRC-7 over valid flag and data, start value all ones.
    function automatic logic [6:0] shs_crc7(input logic [16:0] pl);
        logic [23:0] v;
        v = {pl, SHS_CRC_IVEC};
        for (int i = 23; i >= 7; i--) begin
            if (v[i]) begin
                v = v ^ ({16'h0000, SHS_CRC_POLY} << (i - 7));
            end
        end
        return v[6:0];
    endfunction: shs_crc7

    // True for the addresses that accept a write.
    function automatic logic shs_writable(input logic [7:0] a);
        return (a == SHS_OFS_SYSCTL) || (a == SHS_OFS_RUN) ||
               (a == SHS_OFS_START) || (a == SHS_OFS_STOP);
    endfunction: shs_writable
endpackage: shs_pkg

// ==== rtl/shs_sensor_i2c.sv ====
// Two-wire slave register port and measurement sequencer of the sensor.
// Operation
// - Slave works at 100 kbit/s and 400 kbit/s bus rates.
// - Device never holds the clock line low.
// - No 10-bit address, general call, reset, ID or master features.
// - Answer only address 0x43: byte 0x86 writes, 0x87 reads.
// - First written byte is acknowledged and loads the address pointer.
// - Later bytes store at pointer, pointer plus one; nack if unwritable.
// - Read: pointer write, repeated start, read address; byte returned, pointer advances.
// - Writes to reserved or read-only addresses are nacked, not stored.
// - Reserved addresses read as zero.
// - Single-shot start launches one measurement, then the sensor idles.
// - Stop writes do nothing to a single-shot sensor.
// - Continuous start repeats measurements; stop ends after the current one.
// - Status bit per sensor shows idle or measuring.
// - At step end, run sensors again or enter standby unless low power off.
// - Repeated start or stop writes in a step collapse into one.
// - Start and stop both pending: measure once, then stop.
// - Start clears valid, boots; active rises, then measuring status.
// - Single-shot end: status drops, result valid, standby if low power on, start and stop clear.
// - Continuous: valid stays, data overwritten; after stop final result, bits clear.
// - Control writes act only between measurements; measurements are sequential. Code ignores only start writes to a measuring sensor; others act at once.
// - Stay active while continuous runs or low power is off.
// - Readout carries CRC-7, polynomial x7+x3+1, start value all ones.
// - Reading the lowest readout byte snapshots all bytes for later reads.
`timescale 1ns/1ps
module shs_sensor_i2c
    import shs_pkg::*;
#(
    parameter int BOOT_CYC = SHS_BOOT_CYC,
    parameter int T_CONV_CYC = SHS_TCONV_CYC,
    parameter int H_CONV_CYC = SHS_HCONV_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire logic [15:0] t_value_i,
    input wire logic [15:0] h_value_i,
    output logic active_state_flag,
    output logic [1:0] measure_status
);

    shs_core_s c;
    shs_core_s nxt_c;
    shs_link_s l;
    shs_link_s nxt_l;
    logic [1:0] lrs_ff;
    logic lrst_n;
    logic req_new;
    logic [1:0] inflight;
    logic [1:0] pend;
    logic step_end;
    logic [7:0] base;
    logic scl_r;
    logic scl_f;
    logic st_c;
    logic sp_c;
    logic busy;
    logic rd_go;
    logic wr_go;

    // A new request is seen when the synchronised toggle changes.
    assign req_new = c.rq_s2 ^ c.rq_s3;

    // Sequencer and register file in the core clock domain.
    always_comb begin
        nxt_c = c;
        pend = 2'b00;
        base = SHS_OFS_TVAL;
        nxt_c.rq_s1 = l.req.tgl;
        nxt_c.rq_s2 = c.rq_s1;
        nxt_c.rq_s3 = c.rq_s2;
        inflight = (c.seq == SQ_MEAS && c.cnt != '0) ? c.step : 2'b00;
        step_end = ((c.seq == SQ_BOOT || c.seq == SQ_MEAS) && c.cnt == '0) ||
                   (c.seq == SQ_IDLE);
        case (c.seq)
            SQ_STANDBY: begin
                if (c.start != 2'b00 || !c.lp) begin
                    nxt_c.seq = SQ_BOOT;
                    nxt_c.cnt = SHS_CNT_W'(BOOT_CYC - 1);
                end
            end
            SQ_BOOT: begin
                if (c.cnt != '0) begin
                    nxt_c.cnt = c.cnt - 1'b1;
                end else begin
                    nxt_c.active = 1'b1;
                    pend = c.start;
                end
            end
            SQ_IDLE: begin
                pend = c.start;
            end
            SQ_MEAS: begin
                if (c.cnt != '0) begin
                    nxt_c.cnt = c.cnt - 1'b1;
                end else begin
                    // Completion: store result, clear bits of finished sensors.
                    for (int i = 0; i < 2; i++) begin
                        if (c.step[i]) begin
                            nxt_c.meas[i] = {1'b1, (i == 0) ? t_value_i : h_value_i};
                            if (!c.run[i] || c.stop[i]) begin
                                nxt_c.start[i] = 1'b0;
                                nxt_c.stop[i] = 1'b0;
                            end
                        end
                    end
                    pend = nxt_c.start;
                end
            end
            default: begin
                nxt_c.seq = SQ_STANDBY;
            end
        endcase
        // Next step: run the pending sensors again, idle active, or standby.
        if (step_end) begin
            if (pend != 2'b00) begin
                nxt_c.seq = SQ_MEAS;
                nxt_c.step = pend;
                nxt_c.cnt = SHS_CNT_W'((pend[0] ? T_CONV_CYC : 0) +
                                       (pend[1] ? H_CONV_CYC : 0) - 1);
            end else if (c.lp) begin
                nxt_c.seq = SQ_STANDBY;
                nxt_c.active = 1'b0;
            end else begin
                nxt_c.seq = SQ_IDLE;
            end
        end
        // Register access; applied after the sequencer so a write set wins.
        if (req_new) begin
            if (l.req.we) begin
                case (l.req.addr)
                    SHS_OFS_SYSCTL: nxt_c.lp = l.req.wd[0];
                    SHS_OFS_RUN: nxt_c.run = l.req.wd[1:0];
                    SHS_OFS_START: begin
                        for (int i = 0; i < 2; i++) begin
                            if (l.req.wd[i] && !inflight[i]) begin
                                nxt_c.start[i] = 1'b1;
                                nxt_c.meas[i][16] = 1'b0;
                            end
                        end
                    end
                    SHS_OFS_STOP: begin
                        nxt_c.stop = nxt_c.stop | (l.req.wd[1:0] & c.run);
                    end
                    default: begin
                    end
                endcase
            end else begin
                case (l.req.addr)
                    SHS_OFS_SYSCTL: nxt_c.rdata = {7'h00, c.lp};
                    SHS_OFS_SYSSTA: nxt_c.rdata = {7'h00, c.active};
                    SHS_OFS_RUN: nxt_c.rdata = {6'h00, c.run};
                    SHS_OFS_START: nxt_c.rdata = {6'h00, c.start};
                    SHS_OFS_STOP: nxt_c.rdata = {6'h00, c.stop};
                    SHS_OFS_STAT: nxt_c.rdata = {6'h00, c.stat};
                    default: nxt_c.rdata = 8'h00;
                endcase
                // Readout bytes: the lowest one refreshes the snapshot.
                for (int i = 0; i < 2; i++) begin
                    base = (i == 0) ? SHS_OFS_TVAL : SHS_OFS_HVAL;
                    if (l.req.addr == base) begin
                        nxt_c.snap[i] = {shs_crc7(c.meas[i]), c.meas[i]};
                        nxt_c.rdata = c.meas[i][7:0];
                    end
                    if (l.req.addr == base + 8'h01) begin
                        nxt_c.rdata = c.snap[i][15:8];
                    end
                    if (l.req.addr == base + 8'h02) begin
                        nxt_c.rdata = c.snap[i][23:16];
                    end
                end
            end
            nxt_c.ack_tgl = c.rq_s2;
        end
        // Status rises only once the active flag already stands, so it follows it.
        nxt_c.stat = (nxt_c.seq == SQ_MEAS && c.active) ? nxt_c.step : 2'b00;
    end

    // Core registers; after power-up the device boots, then falls to standby.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            c <= '0;
            c.lp <= SHS_LP_RST;
            c.seq <= SQ_BOOT;
            c.cnt <= SHS_CNT_W'(BOOT_CYC - 1);
        end else begin
            c <= nxt_c;
        end
    end

    // Reset for the link domain, released on the link clock.
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lrs_ff <= 2'b00;
        end else begin
            lrs_ff <= {lrs_ff[0], 1'b1};
        end
    end

    assign lrst_n = lrs_ff[1];

    // Bus line events, from the second and third synchroniser stages.
    // Oversampling on the link clock covers 100 and 400 kbit/s.
    assign scl_r = l.scl_s2 & ~l.scl_s3;
    assign scl_f = ~l.scl_s2 & l.scl_s3;
    assign st_c = l.scl_s2 & l.scl_s3 & l.sda_s3 & ~l.sda_s2;
    assign sp_c = l.scl_s2 & l.scl_s3 & ~l.sda_s3 & l.sda_s2;
    assign busy = l.req.tgl ^ l.ack_s2;

    // Two-wire slave in the link clock domain.
    always_comb begin
        nxt_l = l;
        rd_go = 1'b0;
        wr_go = 1'b0;
        nxt_l.scl_s1 = scl_i;
        nxt_l.scl_s2 = l.scl_s1;
        nxt_l.scl_s3 = l.scl_s2;
        nxt_l.sda_s1 = sda_i;
        nxt_l.sda_s2 = l.sda_s1;
        nxt_l.sda_s3 = l.sda_s2;
        nxt_l.ack_s1 = c.ack_tgl;
        nxt_l.ack_s2 = l.ack_s1;
        if (st_c) begin
            nxt_l.st = LK_ADDR;
            nxt_l.cnt = 4'h0;
        end else if (sp_c) begin
            nxt_l.st = LK_IDLE;
        end else begin
            case (l.st)
                LK_ADDR, LK_PTR, LK_WDATA: begin
                    if (scl_r) begin
                        nxt_l.sh = {l.sh[6:0], l.sda_s2};
                        nxt_l.cnt = l.cnt + 4'h1;
                    end
                    if (scl_f && l.cnt == SHS_BITS) begin
                        nxt_l.cnt = 4'h0;
                        nxt_l.st = LK_ACK;
                        nxt_l.ackb = 1'b1;
                        nxt_l.ret = LK_WDATA;
                        if (l.st == LK_ADDR) begin
                            // Only our own 7-bit address is answered.
                            if (l.sh[7:1] != SHS_DEV_ADDR) begin
                                nxt_l.st = LK_IDLE;
                            end
                            nxt_l.ret = l.sh[0] ? LK_RWAIT : LK_PTR;
                        end else if (l.st == LK_PTR) begin
                            nxt_l.ptr = l.sh;
                        end else begin
                            nxt_l.ptr = l.ptr + 8'h01;
                            if (shs_writable(l.ptr) && !busy) begin
                                wr_go = 1'b1;
                            end else begin
                                nxt_l.ackb = 1'b0;
                            end
                        end
                    end
                end
                LK_ACK: begin
                    if (scl_f) begin
                        nxt_l.st = l.ret;
                        rd_go = (l.ret == LK_RWAIT);
                    end
                end
                LK_RWAIT: begin
                    if (!busy) begin
                        nxt_l.sh = c.rdata;
                        nxt_l.ptr = l.ptr + 8'h01;
                        nxt_l.st = LK_RDATA;
                        nxt_l.cnt = 4'h0;
                    end
                end
                LK_RDATA: begin
                    if (scl_f) begin
                        nxt_l.sh = {l.sh[6:0], 1'b0};
                        nxt_l.cnt = l.cnt + 4'h1;
                        if (l.cnt == SHS_BITS - 4'h1) begin
                            nxt_l.st = LK_RACK;
                        end
                    end
                end
                LK_RACK: begin
                    if (scl_r) begin
                        nxt_l.ackb = l.sda_s2;
                    end
                    // Master ack asks for another byte; nack ends the burst.
                    if (scl_f) begin
                        if (!l.ackb) begin
                            nxt_l.st = LK_RWAIT;
                            rd_go = 1'b1;
                        end else begin
                            nxt_l.st = LK_IDLE;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        // Request to the core, held stable until the toggle is answered.
        if (rd_go || wr_go) begin
            nxt_l.req.tgl = ~l.req.tgl;
            nxt_l.req.we = wr_go;
            nxt_l.req.addr = l.ptr;
            nxt_l.req.wd = l.sh;
        end
        nxt_l.drv = (nxt_l.st == LK_ACK && nxt_l.ackb) ||
                    (nxt_l.st == LK_RDATA && !nxt_l.sh[7]);
    end

    // Link registers; synchronisers start at the idle bus level, so no false edge follows reset.
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            l <= '0;
            l.scl_s1 <= 1'b1;
            l.scl_s2 <= 1'b1;
            l.scl_s3 <= 1'b1;
            l.sda_s1 <= 1'b1;
            l.sda_s2 <= 1'b1;
            l.sda_s3 <= 1'b1;
        end else begin
            l <= nxt_l;
        end
    end

    // Open-drain data pin; the clock pin is input only, never stretched.
    assign sda_o = 1'b0;
    assign sda_oe_n = ~l.drv;
    assign active_state_flag = c.active;
    assign measure_status = c.stat;

    property p_stat_active;
        @(posedge clock) disable iff (!rst_n)
        measure_status != 2'b00 |-> active_state_flag;
    endproperty
    a_stat_active: assert property (p_stat_active)
        else $error("Measuring while not active.");

    property p_boot_first;
        @(posedge clock) disable iff (!rst_n)
        $rose(active_state_flag) |-> $past(c.seq) == SQ_BOOT && measure_status == 2'b00;
    endproperty
    a_boot_first: assert property (p_boot_first)
        else $error("Active rose without boot.");

    property p_single_done;
        @(posedge clock) disable iff (!rst_n)
        (c.seq == SQ_MEAS && c.cnt == '0 && c.step[0] && !c.run[0] && !req_new)
        |=> !c.start[0] && !c.stop[0] && c.meas[0][16] && !measure_status[0];
    endproperty
    a_single_done: assert property (p_single_done)
        else $error("Single shot did not finish cleanly.");

    property p_cont_repeat;
        @(posedge clock) disable iff (!rst_n)
        (c.seq == SQ_MEAS && c.cnt == '0 && c.step[1] && c.run[1] && !c.stop[1] && !req_new)
        |=> c.seq == SQ_MEAS && c.step[1] && c.start[1] && c.meas[1][16];
    endproperty
    a_cont_repeat: assert property (p_cont_repeat)
        else $error("Continuous run did not repeat.");

    property p_stop_single;
        @(posedge clock) disable iff (!rst_n)
        (req_new && l.req.we && l.req.addr == SHS_OFS_STOP && !c.run[0] && !c.stop[0])
        |=> !c.stop[0];
    endproperty
    a_stop_single: assert property (p_stop_single)
        else $error("Stop took effect in single shot.");

    property p_start_valid;
        @(posedge clock) disable iff (!rst_n)
        (req_new && l.req.we && l.req.addr == SHS_OFS_START && l.req.wd[0] &&
         c.seq != SQ_MEAS) |=> !c.meas[0][16] && c.start[0];
    endproperty
    a_start_valid: assert property (p_start_valid)
        else $error("Start did not clear valid.");

    property p_standby;
        @(posedge clock) disable iff (!rst_n)
        (c.seq == SQ_IDLE && c.lp && c.start == 2'b00 && !req_new)
        |=> c.seq == SQ_STANDBY && !active_state_flag;
    endproperty
    a_standby: assert property (p_standby)
        else $error("No standby with low power.");

    property p_stay_active;
        @(posedge clock) disable iff (!rst_n)
        (c.active && !c.lp && !req_new) |=> c.active;
    endproperty
    a_stay_active: assert property (p_stay_active)
        else $error("Left active with low power off.");

    property p_snapshot;
        @(posedge clock) disable iff (!rst_n)
        (req_new && !l.req.we && l.req.addr == SHS_OFS_TVAL)
        |=> c.snap[0] == {shs_crc7($past(c.meas[0])), $past(c.meas[0])} &&
            c.rdata == c.snap[0][7:0];
    endproperty
    a_snapshot: assert property (p_snapshot)
        else $error("Readout snapshot wrong.");

    property p_reserved;
        @(posedge clock) disable iff (!rst_n)
        (req_new && !l.req.we && l.req.addr == 8'h2f) |=> c.rdata == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("Reserved address read nonzero.");

    property p_nack_ro;
        @(posedge link_clk) disable iff (!lrst_n)
        (l.st == LK_WDATA && scl_f && l.cnt == SHS_BITS && !st_c && !sp_c &&
         !shs_writable(l.ptr)) |=> l.st == LK_ACK && !l.drv && l.req == $past(l.req);
    endproperty
    a_nack_ro: assert property (p_nack_ro)
        else $error("Unwritable address was acked.");

    property p_addr;
        @(posedge link_clk) disable iff (!lrst_n)
        (l.st == LK_ADDR && scl_f && l.cnt == SHS_BITS && !st_c && !sp_c &&
         l.sh[7:1] != SHS_DEV_ADDR) |=> l.st == LK_IDLE && !l.drv;
    endproperty
    a_addr: assert property (p_addr)
        else $error("Foreign address answered.");

    property p_ptr_load;
        @(posedge link_clk) disable iff (!lrst_n)
        (l.st == LK_PTR && scl_f && l.cnt == SHS_BITS && !st_c && !sp_c)
        |=> l.ptr == $past(l.sh) && l.drv;
    endproperty
    a_ptr_load: assert property (p_ptr_load)
        else $error("Pointer not loaded.");

    property p_read_serve;
        @(posedge link_clk) disable iff (!lrst_n)
        (l.st == LK_RWAIT && !busy && !st_c && !sp_c)
        |=> l.st == LK_RDATA && l.ptr == $past(l.ptr) + 8'h01;
    endproperty
    a_read_serve: assert property (p_read_serve)
        else $error("Read byte not served.");

    c_single: cover property (@(posedge clock) disable iff (!rst_n)
        c.seq == SQ_MEAS && c.cnt == '0 && !c.run[0] && c.step[0]);
    c_cont: cover property (@(posedge clock) disable iff (!rst_n)
        c.seq == SQ_MEAS && c.cnt == '0 && c.run[1] && !c.stop[1] && c.step[1]);
    c_read: cover property (@(posedge link_clk) disable iff (!lrst_n)
        l.st == LK_RACK && scl_f && !l.ackb);
    c_nack: cover property (@(posedge link_clk) disable iff (!lrst_n)
        l.st == LK_ACK && !l.ackb && l.ret == LK_WDATA);

endmodule: shs_sensor_i2c

// ==== testbench/shs_mst.sv ====
// Two-wire bus master model facing the sensor port.
`timescale 1ns/1ps
module shs_mst (
    output logic scl,
    output logic sda_m,
    input wire logic sda
);
    localparam time QTR = 625ns;
    // The bus idles released, clock high.
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // One bit at 400 kbit/s, data moved only while the clock is low.
    task automatic bit_io(input logic b, output logic r);
        sda_m = b;
        #QTR scl = 1'b1;
        #QTR r = sda;
        #QTR scl = 1'b0;
        #QTR;
    endtask: bit_io
    // Start or repeated start: data falls while the clock is high.
    task automatic start_c();
        sda_m = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_m = 1'b0;
        #QTR scl = 1'b0;
        #QTR;
    endtask: start_c
    // Stop: data rises while the clock is high.
    task automatic stop_c();
        sda_m = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda_m = 1'b1;
        #QTR;
    endtask: stop_c
    // Eight bits then the acknowledge slot; mack is our own answer on reads.
    task automatic byte_io(input logic [7:0] d, input logic mack, output logic [7:0] r,
                           output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
        bit_io(mack, ack);
    endtask: byte_io
endmodule: shs_mst

// ==== testbench/tb_top.sv ====
// Self-checking bench for the sensor two-wire port and sequencer.
`timescale 1ns/1ps
module tb_top;
    import shs_pkg::*;
    logic clock, link_clk, rst_n, scl, sda_m, sda_o, sda_oe_n, active_state_flag;
    logic [15:0] t_value_i, h_value_i;
    logic [1:0] measure_status;
    int bad_count, compares;
    wire sda = sda_m & (sda_oe_n | sda_o); // Open drain line with pull-up.
    shs_sensor_i2c #(.BOOT_CYC(20), .T_CONV_CYC(2000), .H_CONV_CYC(2000)) dut (
        .clock(clock), .rst_n(rst_n), .link_clk(link_clk), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n), .t_value_i(t_value_i), .h_value_i(h_value_i),
        .active_state_flag(active_state_flag), .measure_status(measure_status));
    shs_mst m (.scl(scl), .sda_m(sda_m), .sda(sda));
    // Core clock and an unrelated link clock.
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        link_clk = 1'b0;
        #1.3;
        forever #3 link_clk = ~link_clk;
    end
    // Compares and counts.
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask: check
    // Prints the counts and the verdict, then ends the run.
    task automatic final_report();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask: final_report
    // Writes n bytes from ptr on; ea holds the expected acknowledge of each.
    task automatic wr(input logic [7:0] ptr, input logic [31:0] d, input int n,
                      input logic [3:0] ea);
        logic [7:0] r;
        logic a;
        m.start_c();
        m.byte_io(8'h86, 1'b1, r, a);
        check("write addr ack", {7'h00, a}, 8'h00);
        m.byte_io(ptr, 1'b1, r, a);
        check("ptr ack", {7'h00, a}, 8'h00);
        for (int k = 0; k < n; k++) begin
            m.byte_io(d[8*k+:8], 1'b1, r, a);
            check("data ack", {7'h00, a}, {7'h00, ea[k]});
        end
        m.stop_c();
    endtask: wr
    // Reads n bytes from ptr on and compares them with exp, lowest byte first.
    task automatic rd(input logic [7:0] ptr, input int n, input logic [31:0] exp);
        logic [7:0] r;
        logic a;
        m.start_c();
        m.byte_io(8'h86, 1'b1, r, a);
        m.byte_io(ptr, 1'b1, r, a);
        m.start_c();
        m.byte_io(8'h87, 1'b1, r, a);
        check("read addr ack", {7'h00, a}, 8'h00);
        for (int k = 0; k < n; k++) begin
            m.byte_io(8'hff, k == n - 1, r, a);
            check("read byte", r, exp[8*k+:8]);
        end
        m.stop_c();
    endtask: rd
    // General call, ten-bit prefix and a foreign address all stay unanswered.
    task automatic t_foreign();
        logic [7:0] r;
        logic a;
        logic [7:0] adr[3] = '{8'h00, 8'hf0, 8'h88};
        foreach (adr[i]) begin
            m.start_c();
            m.byte_io(adr[i], 1'b1, r, a);
            check("foreign ack", {7'h00, a}, 8'h01);
        end
        m.stop_c();
    endtask: t_foreign
    // Single shot temperature: boots, measures, returns to standby, result readable.
    task automatic t_single();
        wr(SHS_OFS_START, 32'h01, 1, 4'h0);
        check("active", {7'h00, active_state_flag}, 8'h01);
        check("status", {6'h00, measure_status}, 8'h01);
        repeat (2100) @(posedge clock);
        check("status done", {6'h00, measure_status}, 8'h00);
        check("standby", {7'h00, active_state_flag}, 8'h00);
        rd(8'h2f, 4, 32'h0b49fd00);
    endtask: t_single
    // Continuous humidity, stopped later; the status byte write is refused.
    task automatic t_cont();
        wr(SHS_OFS_RUN, 32'h0202, 2, 4'h0);
        repeat (4100) @(posedge clock);
        check("active cont", {7'h00, active_state_flag}, 8'h01);
        wr(SHS_OFS_STOP, 32'h0003, 2, 4'h2);
        repeat (2100) @(posedge clock);
        check("status stop", {6'h00, measure_status}, 8'h00);
        check("standby stop", {7'h00, active_state_flag}, 8'h00);
    endtask: t_cont
    // Low power off keeps the device active and idle; back on, it returns to standby.
    task automatic t_lowpower();
        wr(SHS_OFS_SYSCTL, 32'h00, 1, 4'h0);
        check("active lp off", {7'h00, active_state_flag}, 8'h01);
        check("status lp off", {6'h00, measure_status}, 8'h00);
        wr(SHS_OFS_SYSCTL, 32'h01, 1, 4'h0);
        check("standby lp on", {7'h00, active_state_flag}, 8'h00);
    endtask: t_lowpower
    // Reset, then the scenarios in turn.
    initial begin
        rst_n = 1'b0;
        t_value_i = 16'h49fd;
        h_value_i = 16'h2e6c;
        bad_count = 0;
        compares = 0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        repeat (60) @(posedge clock);
        t_foreign();
        t_single();
        t_cont();
        t_lowpower();
        final_report();
    end
    // Cuts a hang short.
    initial begin
        #2ms;
        bad_count++;
        final_report();
    end
endmodule: tb_top
